// File: esc_pkg.sv
/*
 * esc_pkg: register offsets, field positions, codes and states of the
 * edge-rate and contention register slice.
 * Assumes: included before esc_field and esc_csr.
 */
package esc_pkg;
	// register sub-addresses
	localparam logic [7:0] REG_LP_CLK = 8'h0A;
	localparam logic [7:0] REG_DATA_HS = 8'h0B;
	localparam logic [7:0] REG_CONT = 8'h0D;
	localparam logic [7:0] SUBADDR_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// field positions (lsb of each two-bit field)
	localparam int A_LP_LSB = 6;
	localparam int B_LP_LSB = 4;
	localparam int CLK_HS_LSB = 0;
	localparam int LANE_HS_STEP = 2;
	localparam int NUM_LANES = 4;
	// contention status bit positions
	localparam int B_NEG_BIT = 5;
	localparam int B_POS_BIT = 4;
	localparam int A_NEG_BIT = 1;
	localparam int A_POS_BIT = 0;
	localparam logic [1:0] RSVD_ZERO = 2'h0;
	localparam logic [3:0] CONT_RESET = 4'h0;
	// low-power edge-rate codes
	localparam logic [1:0] SLEW_RESET = 2'h0;
	localparam logic [1:0] LP_18NS = 2'h0;
	localparam logic [1:0] LP_21NS = 2'h1;
	localparam logic [1:0] LP_15NS = 2'h2;
	localparam logic [1:0] LP_27NS = 2'h3;
	// high-speed edge-rate codes
	localparam logic [1:0] HS_200PS = 2'h0;
	localparam logic [1:0] HS_150PS = 2'h1;
	localparam logic [1:0] HS_250PS = 2'h2;
	localparam logic [1:0] HS_300PS = 2'h3;
	// three-level strap pin encoding
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	// serial host interface
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2C; // arbitrary value
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR_BYTE = 3'b011,
		ST_WR_ACK = 3'b100,
		ST_RD_BYTE = 3'b101,
		ST_RD_ACK = 3'b110
	} esc_state_t;
endpackage

// File: esc_field.sv
/*
 * esc_field: one two-bit edge-rate field, seeded from a strap value once
 * after reset release and rewritable by the host afterwards.
 * Assumes: load_i pulses for one cycle right after reset release.
 */
`timescale 1ns/10ps
module esc_field (
	input wire logic clk_i,
	input wire logic reset_input_pin_i,
	input wire logic load_i,
	input wire logic [1:0] strap_i,
	input wire logic wr_i,
	input wire logic [1:0] wdata_i,
	output logic [1:0] field_o
);
	import esc_pkg::*;

	logic [1:0] field_q;
	logic [1:0] field_d;

	// strap seed first, host writes hold until next reset
	assign field_d = load_i ? strap_i : (wr_i ? wdata_i : field_q);
	assign field_o = field_q;

	// field storage
	always_ff @(posedge clk_i) begin
		if (!reset_input_pin_i) begin
			field_q <= SLEW_RESET;
		end else begin
			field_q <= field_d;
		end
	end
endmodule

// File: esc_csr.sv
/*
 * esc_csr: edge-rate and lane-0 contention registers behind a two-wire
 * serial slave with a sub-address pointer.
 * Assumes: scl_i/sda_i already synchronous to clk_i; the bus wire is
 * low when sda_oen_o is low (sda_o is always 0, open drain).
 */
`timescale 1ns/10ps
module esc_csr #(
	parameter logic [6:0] DEV_ADDR = esc_pkg::DEV_ADDR_DEFAULT
) (
	input wire logic clk_i,
	input wire logic reset_input_pin_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oen_o,
	input wire logic [1:0] cfg_strap_i,
	input wire logic [1:0] slew_strap_i,
	input wire logic a_lane0_pos_contention_i,
	input wire logic a_lane0_neg_contention_i,
	input wire logic b_lane0_pos_contention_i,
	input wire logic b_lane0_neg_contention_i,
	output logic [1:0] a_side_lp_slew_sel_o,
	output logic [1:0] b_side_lp_slew_sel_o,
	output logic [1:0] clock_lane_hs_slew_sel_o,
	output logic [1:0] lane3_hs_slew_sel_o,
	output logic [1:0] lane2_hs_slew_sel_o,
	output logic [1:0] lane1_hs_slew_sel_o,
	output logic [1:0] lane0_hs_slew_sel_o
);
	import esc_pkg::*;

	esc_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic rw_q;
	logic first_q;
	logic sda_oen_q;
	logic sda_out_q;
	logic scl_q;
	logic sda_q;
	logic strap_done_q;
	logic [3:0] cont_q;
	logic [1:0] lane_sel [NUM_LANES];

	// bus conditions
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic byte_done;
	logic addr_hit;
	logic wr_en;
	logic wr_lp_clk;
	logic wr_data_hs;
	logic strap_load;
	logic [1:0] hs_strap;
	logic [7:0] rd_data;
	logic [7:0] lp_clk_word;
	logic [7:0] data_hs_word;
	logic [7:0] cont_word;

	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
	assign bus_stop = scl_i & scl_q & ~sda_q & sda_i;
	assign byte_done = (cnt_q == BITS_PER_BYTE);
	assign addr_hit = (shift_q[7:1] == DEV_ADDR);

	// register write strobes; contention register has no strobe
	assign wr_en = scl_fall & ~bus_start & ~bus_stop & (state_q == ST_WR_BYTE) & byte_done & ~first_q;
	assign wr_lp_clk = wr_en & (ptr_q == REG_LP_CLK);
	assign wr_data_hs = wr_en & (ptr_q == REG_DATA_HS);

	// strap capture in the first cycle after reset release
	assign strap_load = reset_input_pin_i & ~strap_done_q;
	assign hs_strap = (slew_strap_i == LVL_LOW) ? HS_200PS :
		((slew_strap_i == LVL_MID) ? HS_150PS : HS_250PS);

	// read words, reserved bits as zero
	assign lp_clk_word = {a_side_lp_slew_sel_o, b_side_lp_slew_sel_o, RSVD_ZERO, clock_lane_hs_slew_sel_o};
	assign data_hs_word = {lane_sel[3], lane_sel[2], lane_sel[1], lane_sel[0]};
	assign cont_word = {RSVD_ZERO, cont_q[3], cont_q[2], RSVD_ZERO, cont_q[1], cont_q[0]};
	assign rd_data = (ptr_q == REG_LP_CLK) ? lp_clk_word :
		((ptr_q == REG_DATA_HS) ? data_hs_word :
		((ptr_q == REG_CONT) ? cont_word : BYTE_ZERO));

	// edge-rate fields
	esc_field u_a_lp (
		.clk_i(clk_i), .reset_input_pin_i(reset_input_pin_i), .load_i(1'b0), .strap_i(SLEW_RESET),
		.wr_i(wr_lp_clk), .wdata_i(shift_q[A_LP_LSB +: 2]), .field_o(a_side_lp_slew_sel_o)
	);
	esc_field u_b_lp (
		.clk_i(clk_i), .reset_input_pin_i(reset_input_pin_i), .load_i(strap_load), .strap_i(cfg_strap_i),
		.wr_i(wr_lp_clk), .wdata_i(shift_q[B_LP_LSB +: 2]), .field_o(b_side_lp_slew_sel_o)
	);
	esc_field u_clk_hs (
		.clk_i(clk_i), .reset_input_pin_i(reset_input_pin_i), .load_i(strap_load), .strap_i(hs_strap),
		.wr_i(wr_lp_clk), .wdata_i(shift_q[CLK_HS_LSB +: 2]), .field_o(clock_lane_hs_slew_sel_o)
	);

	// data lane fields
	for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
		esc_field u_lane (
			.clk_i(clk_i), .reset_input_pin_i(reset_input_pin_i), .load_i(strap_load), .strap_i(hs_strap),
			.wr_i(wr_data_hs), .wdata_i(shift_q[i * LANE_HS_STEP +: 2]), .field_o(lane_sel[i])
		);
	end
	assign lane3_hs_slew_sel_o = lane_sel[3];
	assign lane2_hs_slew_sel_o = lane_sel[2];
	assign lane1_hs_slew_sel_o = lane_sel[1];
	assign lane0_hs_slew_sel_o = lane_sel[0];
	assign sda_o = sda_out_q;
	assign sda_oen_o = sda_oen_q;

	// pin history, strap flag and contention capture
	always_ff @(posedge clk_i) begin
		if (!reset_input_pin_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			strap_done_q <= 1'b0;
			cont_q <= CONT_RESET;
			sda_out_q <= 1'b0;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			strap_done_q <= 1'b1;
			cont_q <= {b_lane0_neg_contention_i, b_lane0_pos_contention_i,
				a_lane0_neg_contention_i, a_lane0_pos_contention_i};
			sda_out_q <= 1'b0;
		end
	end

	// serial slave sequencer: sample on scl rise, drive on scl fall
	always_ff @(posedge clk_i) begin
		if (!reset_input_pin_i) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_ZERO;
			shift_q <= BYTE_ZERO;
			tx_q <= BYTE_ZERO;
			ptr_q <= SUBADDR_RESET;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			sda_oen_q <= 1'b1;
		end else if (bus_start) begin
			state_q <= ST_ADDR;
			cnt_q <= CNT_ZERO;
			sda_oen_q <= 1'b1;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
			sda_oen_q <= 1'b1;
		end else if (scl_rise) begin
			if (state_q == ST_ADDR || state_q == ST_WR_BYTE) begin
				shift_q <= {shift_q[6:0], sda_i};
				cnt_q <= cnt_q + 4'h1;
			end else if (state_q == ST_RD_BYTE) begin
				cnt_q <= cnt_q + 4'h1;
			end else if (state_q == ST_RD_ACK && sda_i) begin
				state_q <= ST_IDLE; // not acknowledged, read ends
			end
		end else if (scl_fall) begin
			unique case (state_q)
				ST_IDLE: begin
					sda_oen_q <= 1'b1;
				end
				ST_ADDR: begin
					if (byte_done) begin
						if (addr_hit) begin
							sda_oen_q <= 1'b0;
							rw_q <= shift_q[0];
							first_q <= 1'b1;
							state_q <= ST_ADDR_ACK;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK, ST_RD_ACK: begin
					cnt_q <= CNT_ZERO;
					if (state_q == ST_RD_ACK || rw_q) begin
						tx_q <= rd_data;
						ptr_q <= ptr_q + 8'h01;
						sda_oen_q <= rd_data[7];
						state_q <= ST_RD_BYTE;
					end else begin
						sda_oen_q <= 1'b1;
						state_q <= ST_WR_BYTE;
					end
				end
				ST_WR_BYTE: begin
					if (byte_done) begin
						sda_oen_q <= 1'b0;
						state_q <= ST_WR_ACK;
						ptr_q <= first_q ? shift_q : ptr_q + 8'h01;
					end
				end
				ST_WR_ACK: begin
					sda_oen_q <= 1'b1;
					cnt_q <= CNT_ZERO;
					first_q <= 1'b0;
					state_q <= ST_WR_BYTE;
				end
				ST_RD_BYTE: begin
					if (byte_done) begin
						sda_oen_q <= 1'b1;
						state_q <= ST_RD_ACK;
					end else begin
						tx_q <= {tx_q[6:0], 1'b0};
						sda_oen_q <= tx_q[6];
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// checks
	sequence s_strap_seen;
		strap_load;
	endsequence
	sequence s_lp_write;
		wr_lp_clk;
	endsequence

	a_lp_a_write: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		s_lp_write |=> a_side_lp_slew_sel_o == $past(shift_q[A_LP_LSB +: 2])) else $error("a-side lp field missed write");
	a_lp_b_strap: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		s_strap_seen |=> b_side_lp_slew_sel_o == $past(cfg_strap_i)) else $error("b-side lp strap not loaded");
	a_lp_b_write: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		s_lp_write |=> b_side_lp_slew_sel_o == $past(shift_q[B_LP_LSB +: 2])) else $error("b-side lp field missed write");
	a_clk_hs_strap: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		s_strap_seen |=> clock_lane_hs_slew_sel_o != HS_300PS && clock_lane_hs_slew_sel_o == $past(hs_strap))
		else $error("clock lane strap wrong");
	a_lane_strap: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		s_strap_seen |=> lane3_hs_slew_sel_o == $past(hs_strap) && lane0_hs_slew_sel_o == $past(hs_strap))
		else $error("data lane strap wrong");
	a_lane_write: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		wr_data_hs |=> lane3_hs_slew_sel_o == $past(shift_q[7:6]) && lane1_hs_slew_sel_o == $past(shift_q[3:2]))
		else $error("data lane write lost");
	a_field_hold: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		!strap_load && !wr_lp_clk |=> $stable(b_side_lp_slew_sel_o) && $stable(clock_lane_hs_slew_sel_o))
		else $error("field changed without write");
	a_cont_b_read: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		ptr_q == REG_CONT && $past(reset_input_pin_i) |-> rd_data[B_NEG_BIT] == $past(b_lane0_neg_contention_i) &&
		rd_data[B_POS_BIT] == $past(b_lane0_pos_contention_i))
		else $error("b-side contention read wrong");
	a_cont_a_read: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		ptr_q == REG_CONT && $past(reset_input_pin_i) |-> rd_data[A_NEG_BIT] == $past(a_lane0_neg_contention_i) &&
		rd_data[A_POS_BIT] == $past(a_lane0_pos_contention_i))
		else $error("a-side contention read wrong");
	a_strap_once: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		s_strap_seen |=> !strap_load [*3]) else $error("strap sampled again");
	a_read_advance: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		scl_fall && !bus_start && !bus_stop && state_q == ST_ADDR_ACK && rw_q
		|=> tx_q == $past(rd_data) && ptr_q == $past(ptr_q) + 8'h01 && state_q == ST_RD_BYTE)
		else $error("read pointer not advanced");
	a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!reset_input_pin_i)
		(ptr_q == REG_LP_CLK |-> rd_data[3:2] == RSVD_ZERO) and
		(ptr_q == REG_CONT |-> rd_data[7:6] == RSVD_ZERO && rd_data[3:2] == RSVD_ZERO))
		else $error("reserved bits not zero");
endmodule

// File: esc_host.sv
/*
 * esc_host: two-wire host model that frames starts, stops and bytes.
 * Assumes: the bench resolves the data wire with a pull-up and feeds it back
 * on sda_i; all changes land one step after a clock edge.
 */
`timescale 1ns/10ps
module esc_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// idle bus: both lines released
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// wait n edges, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// one bit: data moves mid-low, wire sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		scl_o = 1'b0;
		tick(2);
		sda_o = b;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		r = sda_i;
		tick(2);
	endtask

	// start or repeated start
	task automatic start();
		scl_o = 1'b0;
		tick(2);
		sda_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		sda_o = 1'b0;
		tick(3);
	endtask

	// stop: data rises while clock high
	task automatic stop();
		scl_o = 1'b0;
		tick(2);
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		sda_o = 1'b1;
		tick(3);
	endtask

	// byte out msb first, ack low means taken
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, ack);
	endtask

	// byte in, then ack to go on or nack on the last byte
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask
endmodule

// File: esc_csr_test.sv
/*
 * esc_csr_test: self-checking bench for the edge-rate and contention slice.
 * Assumes: the host model drives the bus; expected results go to a queue
 * and a monitor compares them as results appear.
 */
`timescale 1ns/10ps
module esc_csr_test;
	import esc_pkg::*;
	localparam logic [6:0] ADDR = 7'h2C; // arbitrary value
	logic clk = 1'b0;
	logic reset_input_pin = 1'b0;
	logic scl, host_sda, sda, dev_sda, dev_oen;
	logic [1:0] cfg = 2'h0;
	logic [1:0] slew = 2'h0;
	logic [3:0] cont = 4'h0;
	logic [1:0] a_lp, b_lp, clk_hs, l3, l2, l1, l0;
	logic [13:0] ports;
	logic [15:0] seen;
	logic [15:0] exp_q[$];
	string name_q[$];
	logic [7:0] bytes_q[$];
	event seen_ev;
	int bad_count = 0;
	int comparisons = 0;
	int seed = 32'hA464;

	// clock and wire with pull-up
	always #2 clk = ~clk;
	assign sda = host_sda & (dev_oen | dev_sda);
	assign ports = {a_lp, b_lp, clk_hs, l3, l2, l1, l0};

	esc_csr #(.DEV_ADDR(ADDR)) esc_csr_i (.clk_i(clk), .reset_input_pin_i(reset_input_pin), .scl_i(scl), .sda_i(sda),
		.sda_o(dev_sda), .sda_oen_o(dev_oen), .cfg_strap_i(cfg), .slew_strap_i(slew),
		.a_lane0_pos_contention_i(cont[0]), .a_lane0_neg_contention_i(cont[1]),
		.b_lane0_pos_contention_i(cont[2]), .b_lane0_neg_contention_i(cont[3]),
		.a_side_lp_slew_sel_o(a_lp), .b_side_lp_slew_sel_o(b_lp), .clock_lane_hs_slew_sel_o(clk_hs),
		.lane3_hs_slew_sel_o(l3), .lane2_hs_slew_sel_o(l2), .lane1_hs_slew_sel_o(l1),
		.lane0_hs_slew_sel_o(l0));
	esc_host esc_host_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));

	task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic note(input string n, input logic [15:0] e);
		name_q.push_back(n);
		exp_q.push_back(e);
	endtask

	task automatic got(input logic [15:0] s);
		seen = s;
		->seen_ev;
	endtask

	// monitor takes the oldest note per result
	always @(seen_ev) begin
		check(name_q.pop_front(), exp_q.pop_front(), seen);
	end

	// write burst from bytes_q: sub-address then data
	task automatic wr();
		logic a;
		esc_host_i.start();
		esc_host_i.send({ADDR, 1'b0}, a);
		note("write addr ack", 16'h0000);
		got({15'h0000, a});
		for (int i = 0; i < bytes_q.size(); i++) begin
			esc_host_i.send(bytes_q[i], a);
			note("write ack", 16'h0000);
			got({15'h0000, a});
		end
		esc_host_i.stop();
	endtask

	// read burst from the pointer against bytes_q, nack on the last byte
	task automatic rd(input string n);
		logic a;
		logic [7:0] d;
		esc_host_i.start();
		esc_host_i.send({ADDR, 1'b1}, a);
		note("read addr ack", 16'h0000);
		got({15'h0000, a});
		for (int i = 0; i < bytes_q.size(); i++) begin
			esc_host_i.recv(i == bytes_q.size() - 1, d);
			note(n, {8'h00, bytes_q[i]});
			got({8'h00, d});
		end
		esc_host_i.stop();
	endtask

	task automatic results();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// one pass per slew strap code 0 to 3, each opened by a fresh reset
	initial begin
		logic [7:0] v0, v1, v3;
		logic [1:0] hs;
		logic a;
		for (int s = 0; s < 4; s++) begin
			cfg = 2'($random(seed));
			slew = 2'(s);
			cont = 4'($random(seed));
			reset_input_pin = 1'b0;
			esc_host_i.tick(2);
			reset_input_pin = 1'b1;
			esc_host_i.tick(3);
			hs = (s == 3) ? HS_250PS : slew;
			note("strap fields", {2'h0, SLEW_RESET, cfg, hs, hs, hs, hs, hs});
			got({2'h0, ports});
			bytes_q.delete();
			repeat (10) bytes_q.push_back(BYTE_ZERO);
			bytes_q.push_back({SLEW_RESET, cfg, 2'h0, hs});
			bytes_q.push_back({hs, hs, hs, hs});
			bytes_q.push_back(BYTE_ZERO);
			bytes_q.push_back({2'h0, cont[3:2], 2'h0, cont[1:0]});
			rd("bytes from 00h");
			esc_host_i.start();
			esc_host_i.send({ADDR ^ 7'h01, 1'b0}, a);
			note("foreign addr nack", 16'h0001);
			got({15'h0000, a});
			esc_host_i.stop();
			v0 = {2'(s), 2'(3 - s), 4'($random(seed))};
			v1 = 8'($random(seed));
			v3 = 8'($random(seed));
			bytes_q.delete();
			bytes_q.push_back(REG_LP_CLK);
			bytes_q.push_back(v0);
			bytes_q.push_back(v1);
			bytes_q.push_back(v3);
			bytes_q.push_back(v3);
			wr();
			cont = 4'($random(seed));
			note("written fields", {2'h0, v0[7:6], v0[5:4], v0[1:0], v1});
			got({2'h0, ports});
			bytes_q.delete();
			bytes_q.push_back(REG_LP_CLK);
			wr();
			bytes_q.delete();
			bytes_q.push_back(v0 & 8'hF3);
			bytes_q.push_back(v1);
			bytes_q.push_back(BYTE_ZERO);
			bytes_q.push_back({2'h0, cont[3:2], 2'h0, cont[1:0]});
			rd("read back");
		end
		results();
	end

	// watchdog cuts a hang short
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		results();
	end
endmodule
